// ===== design/msr_pkg.sv
// Package for the minute/second real-time clock: register map, fields, codes and timing.
// Operation
// - Count advances once per second from 00:00 to 59:59, then wraps to zero.
// - Counter write accepted only after key 0x3C then 0xC3 on unlock register.
// - Unlock register is write-only and always reads zero.
// - After first key, any other value than either key discards partial unlock.
// - While unlocked, any value other than second key cancels write permission.
// - One unlock permits exactly one counter write, byte or word.
// - Counter initialized only by power-on reset; system resets leave it running. Here presetn keeps the value but holds the divider, pausing the count.
// - Counting continues always, except in either stop low-power mode. Here it also pauses while presetn is low.
// - Bit 15 written 1 loads the whole register with its initial value.
// - Status flag reads 1 after power-on or bad write, 0 in normal operation.
// - Out-of-range time or BCD digit write sets register to initial value.
// - Minutes in bits 14..8 BCD, increment on seconds roll 59 to 00.
// - Seconds in bits 6..0 BCD, increment on falling edge of 1 Hz tick.
// - Writing 00 seconds at 59 bumps minutes unless minutes written same access.
// - Selector 000 off, 001 every half second, 010 every second.
// - Code 011 fires at 29->30 and 59->00; 100 and others only 59->00.
// - Accepted counter write restarts the 1 Hz and 2 Hz tick phase.
// - Counting starts after power-on reset from initial value, flag set.
package msr_pkg;

  // ==========================================================================
  // Register map: each register owns one word, byte address is four times the index
  localparam logic [15:0] MSR_IDX_UNLOCK = 16'hF0C8;
  localparam logic [15:0] MSR_IDX_COUNT = 16'hF0CA;
  localparam logic [15:0] MSR_IDX_CTRL = 16'hF0CC;
  localparam logic [15:0] MSR_IDX_TICKS = 16'hF0D0;
  localparam logic [17:0] MSR_ADDR_UNLOCK = {MSR_IDX_UNLOCK, 2'h0};
  localparam logic [17:0] MSR_ADDR_COUNT = {MSR_IDX_COUNT, 2'h0};
  localparam logic [17:0] MSR_ADDR_CTRL = {MSR_IDX_CTRL, 2'h0};
  localparam logic [17:0] MSR_ADDR_TICKS = {MSR_IDX_TICKS, 2'h0};

  // ==========================================================================
  // Keys, reset values, field positions
  localparam logic [7:0] MSR_KEY_FIRST = 8'h3C;
  localparam logic [7:0] MSR_KEY_SECOND = 8'hC3;
  localparam logic [15:0] MSR_COUNT_INIT = 16'h8000;
  localparam logic [2:0] MSR_CTRL_INIT = 3'h0;
  localparam int MSR_FLAG_BIT = 15;
  localparam int MSR_MIN_LSB = 8;
  localparam logic [3:0] MSR_ONES_MAX = 4'h9;
  localparam logic [2:0] MSR_TENS_MAX = 3'h5;
  localparam logic [6:0] MSR_BCD_29 = 7'h29;
  localparam logic [6:0] MSR_BCD_59 = 7'h59;

  // ==========================================================================
  // Periodic selector codes
  localparam logic [2:0] MSR_SEL_OFF = 3'h0;
  localparam logic [2:0] MSR_SEL_HALF = 3'h1;
  localparam logic [2:0] MSR_SEL_ONE = 3'h2;
  localparam logic [2:0] MSR_SEL_THIRTY = 3'h3;

  // ==========================================================================
  // Timing
  localparam int MSR_CLK_HZ = 20_000_000;
  localparam int MSR_HALF_SEC_MS = 500;
  localparam int MSR_HALF_SEC_CYC = MSR_CLK_HZ / 1000 * MSR_HALF_SEC_MS;

  // ==========================================================================
  // Unlock sequencer states
  typedef enum logic [2:0] {
    MSR_LK_IDLE = 3'b001,
    MSR_LK_FIRST = 3'b010,
    MSR_LK_OPEN = 3'b100
  } msr_lock_t;

  typedef struct packed {
    logic [2:0] minute_tens_digit;
    logic [3:0] minute_ones_digit;
  } msr_min_t;

  typedef struct packed {
    logic [2:0] second_tens_digit;
    logic [3:0] second_ones_digit;
  } msr_sec_t;

endpackage : msr_pkg

// ===== design/msr_rtc.sv
// Minute/second real-time clock with unlock key, APB slave and periodic request.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module msr_rtc
  import msr_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = MSR_HALF_SEC_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic stop_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rtc_interrupt,
  output logic one_hz_tick,
  output logic two_hz_tick
);

  if (HALF_SEC_CYCLES < 2) begin : g_half_check
    $error("HALF_SEC_CYCLES must be at least 2");
  end

  // ==========================================================================
  // Bus decode
  logic acc;
  logic wr;
  logic hit_unlock;
  logic hit_count;
  logic hit_ctrl;
  logic hit_ticks;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign hit_unlock = paddr == MSR_ADDR_UNLOCK;
  assign hit_count = paddr == MSR_ADDR_COUNT;
  assign hit_ctrl = paddr == MSR_ADDR_CTRL;
  assign hit_ticks = paddr == MSR_ADDR_TICKS;
  assign pready = 1'b1;
  assign pslverr = acc & ~(hit_unlock | hit_count | hit_ctrl | hit_ticks);

  // Each register owns a word; the counter uses lane 0 for seconds, lane 1 for minutes
  logic key_wr;
  logic [7:0] key_val;
  assign key_wr = wr & hit_unlock & pstrb[0];
  assign key_val = pwdata[7:0];

  // ==========================================================================
  // Unlock sequencer
  msr_lock_t lock_q;
  logic cnt_wr_attempt;
  logic cnt_wr_ok;
  assign cnt_wr_attempt = wr & hit_count & (pstrb[0] | pstrb[1]);
  assign cnt_wr_ok = cnt_wr_attempt & (lock_q == MSR_LK_OPEN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= MSR_LK_IDLE;
    end else if (cnt_wr_ok) begin
      lock_q <= MSR_LK_IDLE;
    end else if (key_wr) begin
      case (lock_q)
        MSR_LK_IDLE: begin
          lock_q <= (key_val == MSR_KEY_FIRST) ? MSR_LK_FIRST : MSR_LK_IDLE;
        end
        MSR_LK_FIRST: begin
          if (key_val == MSR_KEY_SECOND) begin
            lock_q <= MSR_LK_OPEN;
          end else if (key_val == MSR_KEY_FIRST) begin
            lock_q <= MSR_LK_FIRST;
          end else begin
            lock_q <= MSR_LK_IDLE;
          end
        end
        MSR_LK_OPEN: begin
          lock_q <= (key_val == MSR_KEY_SECOND) ? MSR_LK_OPEN : MSR_LK_IDLE;
        end
        default: begin
          lock_q <= MSR_LK_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Time base taps: 2 Hz falls every half second, 1 Hz falls every second
  logic [31:0] div_q;
  logic [31:0] div_d;
  logic half_wrap;
  assign half_wrap = div_q == 32'(HALF_SEC_CYCLES - 1);
  assign div_d = half_wrap ? '0 : div_q + 32'h1;

  // The 2 Hz tap is high in the second half of each half second, so both taps
  // fall on the same edge once a second and the count steps exactly there

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      two_hz_tick <= 1'b0;
      one_hz_tick <= 1'b0;
    end else if (cnt_wr_ok) begin
      div_q <= '0;
      two_hz_tick <= 1'b0;
      one_hz_tick <= 1'b0;
    end else if (!stop_mode) begin
      div_q <= div_d;
      two_hz_tick <= div_d >= 32'(HALF_SEC_CYCLES / 2);
      if (half_wrap) begin
        one_hz_tick <= ~one_hz_tick;
      end
    end
  end

  logic sec_step;
  logic half_step;
  assign half_step = half_wrap & ~stop_mode & ~cnt_wr_ok;
  assign sec_step = half_step & one_hz_tick;

  // ==========================================================================
  // Counter, reset only by power-on
  logic flag_q;
  msr_min_t min_q;
  msr_sec_t sec_q;
  logic [7:0] wsec;
  logic [7:0] wmin;
  logic wr_sec;
  logic wr_min;
  logic [15:0] wval;
  logic w_bad;
  logic sec_59;
  logic sec_29;
  assign wsec = pwdata[7:0];
  assign wmin = pwdata[15:8];
  assign wr_sec = pstrb[0];
  assign wr_min = pstrb[1];
  assign wval = {wr_min ? wmin : {flag_q, min_q}, 1'b0, wr_sec ? wsec[6:0] : sec_q};
  assign w_bad = wval[14:12] > MSR_TENS_MAX || wval[11:8] > MSR_ONES_MAX
              || wval[6:4] > MSR_TENS_MAX || wval[3:0] > MSR_ONES_MAX;
  assign sec_59 = sec_q == MSR_BCD_59;
  assign sec_29 = sec_q == MSR_BCD_29;

  function automatic msr_min_t msr_min_inc(input msr_min_t m);
    msr_min_t r;
    r = m;
    if (m.minute_ones_digit == MSR_ONES_MAX) begin
      r.minute_ones_digit = 4'h0;
      r.minute_tens_digit = (m.minute_tens_digit == MSR_TENS_MAX) ? 3'h0
                          : m.minute_tens_digit + 3'h1;
    end else begin
      r.minute_ones_digit = m.minute_ones_digit + 4'h1;
    end
    return r;
  endfunction : msr_min_inc

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      flag_q <= MSR_COUNT_INIT[MSR_FLAG_BIT];
      min_q <= '0;
      sec_q <= '0;
    end else if (cnt_wr_ok) begin
      if (wval[MSR_FLAG_BIT] || w_bad) begin
        flag_q <= MSR_COUNT_INIT[MSR_FLAG_BIT];
        min_q <= '0;
        sec_q <= '0;
      end else begin
        flag_q <= 1'b0;
        sec_q <= wval[6:0];
        if (!wr_min && sec_59 && wval[6:0] == 7'h0) begin
          min_q <= msr_min_inc(min_q);
        end else begin
          min_q <= wval[14:8];
        end
      end
    end else if (sec_step) begin
      if (sec_q.second_ones_digit == MSR_ONES_MAX) begin
        sec_q.second_ones_digit <= 4'h0;
        if (sec_q.second_tens_digit == MSR_TENS_MAX) begin
          sec_q.second_tens_digit <= 3'h0;
          min_q <= msr_min_inc(min_q);
        end else begin
          sec_q.second_tens_digit <= sec_q.second_tens_digit + 3'h1;
        end
      end else begin
        sec_q.second_ones_digit <= sec_q.second_ones_digit + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Periodic request selector
  logic [2:0] periodic_irq_select_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_irq_select_q <= MSR_CTRL_INIT;
    end else if (wr & hit_ctrl & pstrb[0]) begin
      periodic_irq_select_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_interrupt <= 1'b0;
    end else begin
      case (periodic_irq_select_q)
        MSR_SEL_OFF: rtc_interrupt <= 1'b0;
        MSR_SEL_HALF: rtc_interrupt <= half_step;
        MSR_SEL_ONE: rtc_interrupt <= sec_step;
        MSR_SEL_THIRTY: rtc_interrupt <= sec_step & (sec_29 | sec_59);
        default: rtc_interrupt <= sec_step & sec_59;
      endcase
    end
  end

  // ==========================================================================
  // Read data, registered on the setup cycle so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      if (hit_count) begin
        prdata <= {16'h0, flag_q, min_q, 1'b0, sec_q};
      end else if (hit_ctrl) begin
        prdata <= {29'h0, periodic_irq_select_q};
      end else if (hit_ticks) begin
        prdata <= {29'h0, lock_q == MSR_LK_OPEN, one_hz_tick, two_hz_tick};
      end else begin
        prdata <= '0;
      end
    end
  end

endmodule : msr_rtc

// ===== verif/msr_rtc_assertions.sv
// Checker of bus answers, read values and stop behaviour of the minute/second clock.
`timescale 1ns/1ps
module msr_rtc_assertions
  import msr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stop_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic rtc_interrupt,
  input wire logic one_hz_tick,
  input wire logic two_hz_tick
);
  // ====================
  // Helpers
  logic mapped;
  logic rd_cnt;
  logic rd_key;
  logic cnt_wr;
  assign mapped = paddr inside {MSR_ADDR_UNLOCK, MSR_ADDR_COUNT, MSR_ADDR_CTRL,
    MSR_ADDR_TICKS};
  assign rd_cnt = psel && !penable && !pwrite && (paddr == MSR_ADDR_COUNT);
  assign rd_key = psel && !penable && !pwrite && (paddr == MSR_ADDR_UNLOCK);
  // An accepted counter write restarts the taps even in stop
  assign cnt_wr = psel && penable && pwrite && (paddr == MSR_ADDR_COUNT);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // Properties
  a_bad_addr_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error answer on unmapped access");
  a_good_addr_ok: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error answer on mapped access");
  a_key_reads_zero: assert property (rd_key |=> prdata == 32'h0)
    else $error("unlock register read not zero");
  a_gap_bit_zero: assert property (rd_cnt |=> !prdata[7])
    else $error("gap bit of counter read as one");
  a_min_bcd_ok: assert property (rd_cnt |=> prdata[14:12] <= MSR_TENS_MAX &&
    prdata[11:8] <= MSR_ONES_MAX) else $error("minute digits out of range");
  a_sec_bcd_ok: assert property (rd_cnt |=> prdata[6:4] <= MSR_TENS_MAX &&
    prdata[3:0] <= MSR_ONES_MAX) else $error("second digits out of range");
  a_stop_taps_hold: assert property (stop_mode && $past(stop_mode) && !$past(cnt_wr) |->
    $stable(one_hz_tick) && $stable(two_hz_tick)) else $error("taps moved in stop");
  a_stop_irq_quiet: assert property (stop_mode [*3] |-> !rtc_interrupt)
    else $error("request raised in stop");
  a_irq_one_cycle: assert property (rtc_interrupt |=> !rtc_interrupt)
    else $error("request longer than one cycle");
endmodule : msr_rtc_assertions

bind msr_rtc msr_rtc_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .stop_mode(stop_mode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .rtc_interrupt(rtc_interrupt),
  .one_hz_tick(one_hz_tick), .two_hz_tick(two_hz_tick));

// ===== verif/msr_rtc_tb_top.sv
// Self-checking testbench of the minute/second clock driven over APB.
`timescale 1ns/1ps
module msr_rtc_tb_top;
  import msr_pkg::*;
  // ====================
  // Signals and design
  logic pclk = 1'h0, presetn = 1'h0, por_n = 1'h0, stop_mode = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, rtc_interrupt;
  int err_total = 0, n_tests = 0, cyc = 0, irq_n = 0;
  // Four cycles a half second keeps each second at eight cycles
  msr_rtc #(.HALF_SEC_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .por_n(por_n),
    .stop_mode(stop_mode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_interrupt(rtc_interrupt), .one_hz_tick(), .two_hz_tick());
  always #25 pclk = ~pclk;
  // Sampled on the falling edge so reading the count never races the pulse
  always @(negedge pclk) if (rtc_interrupt === 1'h1) irq_n++;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end
  // ====================
  // Tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
    input logic [3:0] s);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic kw(input logic [7:0] v);
    apb(1'h1, MSR_ADDR_UNLOCK, {24'h0, v}, 4'h1);
  endtask : kw
  task automatic cw(input logic [31:0] d, input logic [3:0] s);
    apb(1'h1, MSR_ADDR_COUNT, d, s);
  endtask : cw
  task automatic wt(input logic [15:0] t);
    kw(MSR_KEY_FIRST);
    kw(MSR_KEY_SECOND);
    cw({16'h0, t}, 4'h3);
  endtask : wt
  task automatic rdc(input logic [15:0] e);
    apb(1'h0, MSR_ADDR_COUNT, 32'h0, 4'h0);
    chk(r[15:0], e);
  endtask : rdc
  // ====================
  // Scenarios
  task automatic t_por();
    apb(1'h0, MSR_ADDR_UNLOCK, 32'h0, 4'h0);
    chk(r, 32'h0);
    apb(1'h0, MSR_ADDR_COUNT, 32'h0, 4'h0);
    chk(r, {16'h0, MSR_COUNT_INIT});
    apb(1'h0, MSR_ADDR_CTRL, 32'h0, 4'h0);
    chk(r[2:0], MSR_CTRL_INIT);
    apb(1'h0, 18'h3C380, 32'h0, 4'h0);
    chk(r, 32'h0);
  endtask : t_por
  task automatic t_lock();
    wt(16'h2939); rdc(16'h2939);
    cw(32'h1111, 4'h3); rdc(16'h2939);
    kw(MSR_KEY_FIRST); kw(8'h55); kw(MSR_KEY_SECOND); cw(32'h2222, 4'h3);
    rdc(16'h2939);
    kw(MSR_KEY_FIRST); kw(MSR_KEY_SECOND); kw(8'h55); cw(32'h2222, 4'h3);
    rdc(16'h2939);
    kw(MSR_KEY_FIRST); kw(MSR_KEY_SECOND); cw(32'h45, 4'h1); cw(32'h3300, 4'h2);
    rdc(16'h2945);
    wt(16'h6000); rdc(MSR_COUNT_INIT);
    wt(16'h1A00); rdc(MSR_COUNT_INIT);
    wt(16'h0185); rdc(16'h0105);
    wt(16'h8123); rdc(MSR_COUNT_INIT);
    wt(16'h1259); kw(MSR_KEY_FIRST); kw(MSR_KEY_SECOND); cw(32'h0, 4'h1);
    rdc(16'h1300);
    wt(16'h1259); wt(16'h1400); rdc(16'h1400);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdc(16'h1400);
    rdc(16'h1400);
    stop_mode <= 1'h0;
  endtask : t_lock
  task automatic t_count();
    wt(16'h5958); rdc(16'h5958);
    repeat (5) @(posedge pclk);
    rdc(16'h5959);
    repeat (5) @(posedge pclk);
    rdc(16'h0000);
  endtask : t_count
  task automatic t_irq();
    logic [15:0] tm [8] = '{16'h29, 16'h29, 16'h29, 16'h29, 16'h29, 16'h29, 16'h59, 16'h59};
    logic [2:0] cd [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h3, 3'h4};
    int ex [8] = '{0, 2, 1, 1, 0, 0, 1, 1};
    int base;
    for (int i = 0; i < 8; i++) begin
      wt(tm[i]);
      apb(1'h1, MSR_ADDR_CTRL, {29'h0, cd[i]}, 4'h1);
      repeat (2) @(posedge pclk);
      base = irq_n;
      repeat (10) @(posedge pclk);
      chk(irq_n - base, ex[i]);
      apb(1'h1, MSR_ADDR_CTRL, 32'h0, 4'h1);
    end
  endtask : t_irq
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    por_n <= 1'h1;
    @(posedge pclk);
    t_por();
    stop_mode <= 1'h1;
    t_lock();
    t_count();
    t_irq();
    stop_test();
  end
endmodule : msr_rtc_tb_top
